//--- common/idcyc_defines.vh
/*
  Opcode patterns, mode codes and clock-count constants for the
  instruction decode and cycle-timing block.
  Assumes inclusion by bare name from the decoder file only.
*/
`ifndef IDCYC_DEFINES_VH
`define IDCYC_DEFINES_VH

`define IDCYC_MODE_REAL      2'h0
`define IDCYC_MODE_VIRT      2'h1
`define IDCYC_MODE_PROT      2'h2

`define IDCYC_OP_ESCAPE      8'h0F
`define IDCYC_OP_SEG_LOAD    8'h8E
`define IDCYC_OP_STORE_ALL   8'h60
`define IDCYC_OP_INT_CLR     8'hFA
`define IDCYC_OP_INT_SET     8'hFB
`define IDCYC_OP_ADJ_MUL     8'hD4
`define IDCYC_OP_ADJ_DIV     8'hD5
`define IDCYC_ADJ_BASE       8'h0A
`define IDCYC_OP_ADD_IMM     6'h20
`define IDCYC_OP_MOVE_IMM_R  4'hB
`define IDCYC_OP_ACC_LOAD    7'h50
`define IDCYC_OP_ACC_STORE   7'h51
`define IDCYC_OP_PUSH_R      5'h0A
`define IDCYC_OP_POP_R       5'h0B
`define IDCYC_OP_IN_FIXED    7'h72
`define IDCYC_OP_GRP3        7'h7B
`define IDCYC_OP_SHIFT1      7'h68
`define IDCYC_OP_SHIFTCL     7'h69
`define IDCYC_OP_SHIFTIMM    7'h60
`define IDCYC_OP2_SIGN_EXT   7'h5F
`define IDCYC_OP2_ZERO_EXT   7'h5B

`define IDCYC_CLK_MOVE_IMM   8'h02
`define IDCYC_CLK_ACC_LOAD   8'h04
`define IDCYC_CLK_ACC_STORE  8'h02
`define IDCYC_CLK_SEG_R      8'h02
`define IDCYC_CLK_SEG_M      8'h05
`define IDCYC_CLK_SEG_PR     8'h16
`define IDCYC_CLK_SEG_PM     8'h17
`define IDCYC_CLK_EXT_R      8'h03
`define IDCYC_CLK_EXT_M      8'h06
`define IDCYC_CLK_PUSH_REAL  8'h02
`define IDCYC_CLK_PUSH_PROT  8'h04
`define IDCYC_CLK_POP        8'h06
`define IDCYC_CLK_ALL_REAL   8'h12
`define IDCYC_CLK_ALL_PROT   8'h22
`define IDCYC_CLK_IN_REAL    8'h0E
`define IDCYC_CLK_IN_VIRT    8'h1B
`define IDCYC_CLK_IN_PRIV    8'h08
`define IDCYC_CLK_IN_UNPRIV  8'h1D
`define IDCYC_CLK_INTF       8'h08
`define IDCYC_CLK_ALU_R      8'h02
`define IDCYC_CLK_ALU_DM     8'h07
`define IDCYC_CLK_ALU_SM     8'h06
`define IDCYC_CLK_MUL_MIN    8'h0C
`define IDCYC_CLK_MUL_MB     8'h0F
`define IDCYC_CLK_MUL_MD     8'h11
`define IDCYC_CLK_DIVU_B     8'h0E
`define IDCYC_CLK_DIVU_W     8'h16
`define IDCYC_CLK_DIVU_D     8'h26
`define IDCYC_CLK_DIVS_B     8'h13
`define IDCYC_CLK_DIVS_W     8'h1B
`define IDCYC_CLK_DIVS_D     8'h2B
`define IDCYC_CLK_DIVU_MB    8'h03
`define IDCYC_CLK_DIVD_MD    8'h05
`define IDCYC_CLK_ADJ_MUL    8'h11
`define IDCYC_CLK_ADJ_DIV    8'h13
`define IDCYC_CLK_SHF_R      8'h03
`define IDCYC_CLK_SHF_M      8'h07
`define IDCYC_CLK_RCY_R      8'h09
`define IDCYC_CLK_RCY_M      8'h0A
`define IDCYC_CLK_EA2        8'h01
`define IDCYC_CLK_MIS_1      8'h02
`define IDCYC_CLK_MIS_2      8'h04
`define IDCYC_CLK_ODD_1      8'h04
`define IDCYC_CLK_ODD_2      8'h08

`define IDCYC_G_NONE         4'h0
`define IDCYC_G_MOVE         4'h1
`define IDCYC_G_SEG          4'h2
`define IDCYC_G_EXTEND       4'h3
`define IDCYC_G_STACK        4'h4
`define IDCYC_G_PORT         4'h5
`define IDCYC_G_FLAG         4'h6
`define IDCYC_G_ARITH        4'h7
`define IDCYC_G_MUL          4'h8
`define IDCYC_G_DIV          4'h9
`define IDCYC_G_ADJUST       4'hA
`define IDCYC_G_SHIFT        4'hB

`endif

//--- logic/idcyc_decode.v
/*
  Instruction decode and cycle-count unit: takes the first bytes of an
  instruction from the prefetch side and produces a group code, operand
  attributes and an execution clock budget including address, alignment
  and wait-state penalties.
  Assumes the prefetch side presents up to three bytes with a one-cycle
  strobe, and the execution side samples the results on done.
*/
`timescale 1ns/1ps
`include "idcyc_defines.vh"

module idcyc_decode
(
  clk_sys,
  reset_n,
  clk_en,
  insn_valid,
  insn_byte0,
  insn_byte1,
  insn_byte2,
  op_mode,
  priv_ok,
  ea_two_regs,
  opnd_32,
  opnd_odd,
  opnd_misaligned,
  wait_states,
  data_accesses,
  mult_sig_bits,
  disp_present,
  imm_present,
  byte_count,
  dec_done,
  dec_group,
  dec_subop,
  dec_byte_op,
  dec_reg_is_dest,
  dec_mem_opnd,
  dec_reg_field,
  dec_unknown,
  dec_clocks,
  dec_components
);
  input  wire       clk_sys;
  input  wire       reset_n;
  input  wire       clk_en;
  input  wire       insn_valid;
  input  wire [7:0] insn_byte0;
  input  wire [7:0] insn_byte1;
  input  wire [7:0] insn_byte2;
  input  wire [1:0] op_mode;
  input  wire       priv_ok;
  input  wire       ea_two_regs;
  input  wire       opnd_32;
  input  wire       opnd_odd;
  input  wire       opnd_misaligned;
  input  wire [3:0] wait_states;
  input  wire [1:0] data_accesses;
  input  wire [5:0] mult_sig_bits;
  input  wire       disp_present;
  input  wire       imm_present;
  input  wire [3:0] byte_count;
  output reg        dec_done;
  output reg  [3:0] dec_group;
  output reg  [2:0] dec_subop;
  output reg        dec_byte_op;
  output reg        dec_reg_is_dest;
  output reg        dec_mem_opnd;
  output reg  [2:0] dec_reg_field;
  output reg        dec_unknown;
  output reg  [7:0] dec_clocks;
  output reg  [3:0] dec_components;

  reg  [3:0] grp_d;
  reg  [2:0] sub_d;
  reg        byte_d;
  reg        dest_d;
  reg  [2:0] regf_d;
  reg  [7:0] base_d;
  reg        rmw_d;
  reg        touches_d;
  reg  [7:0] pen_d;
  reg  [3:0] comp_d;

  wire       w_bit  = insn_byte0[0];
  wire [1:0] modf   = insn_byte1[7:6];
  wire [2:0] ttt    = insn_byte1[5:3];
  wire       mem_op = (modf != 2'h3);
  // Mode code 3 is treated as protected
  wire       prot   = op_mode[1];

  // Pick register or memory figure
  function [7:0] pick;
    input       is_mem;
    input [7:0] reg_clk;
    input [7:0] mem_clk;
    begin
      pick = is_mem ? mem_clk : reg_clk;
    end
  endfunction

  // Operand size: byte, 16-bit or 32-bit
  function [1:0] opsize;
    input wbit;
    input is32;
    begin
      opsize = !wbit ? 2'h0 : (is32 ? 2'h2 : 2'h1);
    end
  endfunction

  // Byte-wise low bound plus significant multiplier bits, capped by width
  function [7:0] mul_clk;
    input [1:0] sz;
    input [5:0] bits;
    input       is_mem;
    reg   [7:0] span;
    reg   [7:0] used;
    begin
      span = (sz == 2'h0) ? 8'h05 : ((sz == 2'h1) ? 8'h0D : 8'h1D);
      used = ({2'h0, bits} > span) ? span : {2'h0, bits};
      mul_clk = `IDCYC_CLK_MUL_MIN + used;
      if (is_mem)
      begin
        mul_clk = mul_clk + ((sz == 2'h2) ? (`IDCYC_CLK_MUL_MD - `IDCYC_CLK_MUL_MIN)
                                          : (`IDCYC_CLK_MUL_MB - `IDCYC_CLK_MUL_MIN));
      end
    end
  endfunction

  always @*
  begin
    grp_d     = `IDCYC_G_NONE;
    sub_d     = 3'h0;
    byte_d    = !w_bit;
    dest_d    = insn_byte0[1];
    regf_d    = ttt;
    base_d    = 8'h00;
    rmw_d     = 1'b0;
    touches_d = mem_op;
    if (insn_byte0[7:4] == `IDCYC_OP_MOVE_IMM_R)
    begin
      grp_d     = `IDCYC_G_MOVE;
      byte_d    = !insn_byte0[3];
      regf_d    = insn_byte0[2:0];
      dest_d    = 1'b1;
      touches_d = 1'b0;
      base_d    = `IDCYC_CLK_MOVE_IMM;
    end
    else if (insn_byte0[7:1] == `IDCYC_OP_ACC_LOAD || insn_byte0[7:1] == `IDCYC_OP_ACC_STORE)
    begin
      grp_d     = `IDCYC_G_MOVE;
      sub_d     = {2'h0, insn_byte0[1]};
      dest_d    = !insn_byte0[1];
      regf_d    = 3'h0;
      touches_d = 1'b1;
      base_d    = insn_byte0[1] ? `IDCYC_CLK_ACC_STORE : `IDCYC_CLK_ACC_LOAD;
    end
    else if (insn_byte0 == `IDCYC_OP_SEG_LOAD)
    begin
      grp_d  = `IDCYC_G_SEG;
      byte_d = 1'b0;
      base_d = prot ? pick(mem_op, `IDCYC_CLK_SEG_PR, `IDCYC_CLK_SEG_PM)
                    : pick(mem_op, `IDCYC_CLK_SEG_R, `IDCYC_CLK_SEG_M);
    end
    else if (insn_byte0 == `IDCYC_OP_ESCAPE &&
             (insn_byte1[7:1] == `IDCYC_OP2_SIGN_EXT || insn_byte1[7:1] == `IDCYC_OP2_ZERO_EXT))
    begin
      grp_d     = `IDCYC_G_EXTEND;
      sub_d     = {2'h0, insn_byte1[3]};
      byte_d    = !insn_byte1[0];
      dest_d    = 1'b1;
      regf_d    = insn_byte2[5:3];
      touches_d = (insn_byte2[7:6] != 2'h3);
      base_d    = pick(touches_d, `IDCYC_CLK_EXT_R, `IDCYC_CLK_EXT_M);
    end
    else if (insn_byte0[7:3] == `IDCYC_OP_PUSH_R || insn_byte0[7:3] == `IDCYC_OP_POP_R)
    begin
      grp_d     = `IDCYC_G_STACK;
      sub_d     = {2'h0, insn_byte0[3]};
      byte_d    = 1'b0;
      dest_d    = insn_byte0[3];
      regf_d    = insn_byte0[2:0];
      touches_d = 1'b1;
      if (insn_byte0[3])
        base_d = `IDCYC_CLK_POP;
      else
        base_d = prot ? `IDCYC_CLK_PUSH_PROT : `IDCYC_CLK_PUSH_REAL;
    end
    else if (insn_byte0 == `IDCYC_OP_STORE_ALL)
    begin
      grp_d     = `IDCYC_G_STACK;
      sub_d     = 3'h2;
      byte_d    = 1'b0;
      touches_d = 1'b1;
      base_d    = prot ? `IDCYC_CLK_ALL_PROT : `IDCYC_CLK_ALL_REAL;
    end
    else if (insn_byte0[7:1] == `IDCYC_OP_IN_FIXED)
    begin
      grp_d     = `IDCYC_G_PORT;
      dest_d    = 1'b1;
      regf_d    = 3'h0;
      touches_d = 1'b1;
      case (op_mode)
        `IDCYC_MODE_REAL: base_d = `IDCYC_CLK_IN_REAL;
        `IDCYC_MODE_VIRT: base_d = `IDCYC_CLK_IN_VIRT;
        default:          base_d = priv_ok ? `IDCYC_CLK_IN_PRIV : `IDCYC_CLK_IN_UNPRIV;
      endcase
    end
    else if (insn_byte0 == `IDCYC_OP_INT_CLR || insn_byte0 == `IDCYC_OP_INT_SET)
    begin
      grp_d     = `IDCYC_G_FLAG;
      sub_d     = {2'h0, insn_byte0[0]};
      touches_d = 1'b0;
      base_d    = `IDCYC_CLK_INTF;
    end
    else if (insn_byte0[7:2] == `IDCYC_OP_ADD_IMM &&
             (ttt == 3'h0 || ttt == 3'h2 || ttt == 3'h3 || ttt == 3'h5 || ttt == 3'h7))
    begin
      grp_d  = `IDCYC_G_ARITH;
      sub_d  = ttt;
      dest_d = 1'b0;
      rmw_d  = mem_op && (ttt != 3'h7);
      // Compare never writes back, so its memory form is cheaper
      base_d = pick(mem_op, `IDCYC_CLK_ALU_R, (ttt == 3'h7) ? `IDCYC_CLK_ALU_SM - 8'h01 : `IDCYC_CLK_ALU_DM);
    end
    else if (insn_byte0[7:6] == 2'h0 && insn_byte0[2] == 1'b0 &&
             (insn_byte0[5:3] == 3'h0 || insn_byte0[5:3] == 3'h3 || insn_byte0[5:3] == 3'h5))
    begin
      grp_d  = `IDCYC_G_ARITH;
      sub_d  = insn_byte0[5:3];
      rmw_d  = mem_op && !insn_byte0[1];
      base_d = !mem_op ? `IDCYC_CLK_ALU_R
             : (insn_byte0[1] ? `IDCYC_CLK_ALU_SM : `IDCYC_CLK_ALU_DM);
    end
    else if (insn_byte0[7:1] == `IDCYC_OP_GRP3 && ttt[2] && ttt != 3'h5)
    begin
      dest_d = 1'b1;
      regf_d = 3'h0;
      sub_d  = ttt;
      if (ttt == 3'h4)
      begin
        grp_d  = `IDCYC_G_MUL;
        base_d = mul_clk(opsize(w_bit, opnd_32), mult_sig_bits, mem_op);
      end
      else
      begin
        grp_d = `IDCYC_G_DIV;
        case (opsize(w_bit, opnd_32))
          2'h0:    base_d = ttt[0] ? `IDCYC_CLK_DIVS_B : `IDCYC_CLK_DIVU_B;
          2'h1:    base_d = ttt[0] ? `IDCYC_CLK_DIVS_W : `IDCYC_CLK_DIVU_W;
          default: base_d = ttt[0] ? `IDCYC_CLK_DIVS_D : `IDCYC_CLK_DIVU_D;
        endcase
        if (mem_op)
          base_d = base_d + ((opsize(w_bit, opnd_32) == 2'h2) ? `IDCYC_CLK_DIVD_MD : `IDCYC_CLK_DIVU_MB);
      end
    end
    else if ((insn_byte0 == `IDCYC_OP_ADJ_MUL || insn_byte0 == `IDCYC_OP_ADJ_DIV) &&
             insn_byte1 == `IDCYC_ADJ_BASE)
    begin
      grp_d     = `IDCYC_G_ADJUST;
      sub_d     = {2'h0, insn_byte0[0]};
      touches_d = 1'b0;
      base_d    = insn_byte0[0] ? `IDCYC_CLK_ADJ_DIV : `IDCYC_CLK_ADJ_MUL;
    end
    else if ((insn_byte0[7:1] == `IDCYC_OP_SHIFT1 || insn_byte0[7:1] == `IDCYC_OP_SHIFTCL ||
              insn_byte0[7:1] == `IDCYC_OP_SHIFTIMM) && ttt != 3'h6)
    begin
      grp_d  = `IDCYC_G_SHIFT;
      sub_d  = ttt;
      dest_d = 1'b0;
      rmw_d  = mem_op;
      if (ttt == 3'h2 || ttt == 3'h3)
        base_d = pick(mem_op, `IDCYC_CLK_RCY_R, `IDCYC_CLK_RCY_M);
      else
        base_d = pick(mem_op, `IDCYC_CLK_SHF_R, `IDCYC_CLK_SHF_M);
    end
    if (grp_d == `IDCYC_G_NONE)
      touches_d = 1'b0;
  end

  // Wait states add for every decoded group; address and alignment penalties only apply when the operand really lives in memory
  always @*
  begin
    pen_d = {4'h0, wait_states} * {6'h00, data_accesses};
    if (touches_d && ea_two_regs)
      pen_d = pen_d + `IDCYC_CLK_EA2;
    if (touches_d && opnd_32 && opnd_odd && !byte_d)
      pen_d = pen_d + (rmw_d ? `IDCYC_CLK_ODD_2 : `IDCYC_CLK_ODD_1);
    else if (touches_d && !byte_d && ((opnd_32 && !opnd_odd) || opnd_misaligned))
      pen_d = pen_d + (rmw_d ? `IDCYC_CLK_MIS_2 : `IDCYC_CLK_MIS_1);
    comp_d = byte_count + {3'h0, disp_present} + {3'h0, imm_present};
  end

  always @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      dec_done        <= 1'b0;
      dec_group       <= `IDCYC_G_NONE;
      dec_subop       <= 3'h0;
      dec_byte_op     <= 1'b0;
      dec_reg_is_dest <= 1'b0;
      dec_mem_opnd    <= 1'b0;
      dec_reg_field   <= 3'h0;
      dec_unknown     <= 1'b0;
      dec_clocks      <= 8'h00;
      dec_components  <= 4'h0;
    end
    else if (clk_en)
    begin
      dec_done <= insn_valid;
      if (insn_valid)
      begin
        dec_group       <= grp_d;
        dec_subop       <= sub_d;
        dec_byte_op     <= byte_d;
        dec_reg_is_dest <= dest_d;
        dec_mem_opnd    <= touches_d;
        dec_reg_field   <= regf_d;
        dec_unknown     <= (grp_d == `IDCYC_G_NONE);
        dec_clocks      <= (grp_d == `IDCYC_G_NONE) ? 8'h00 : base_d + pen_d;
        dec_components  <= comp_d;
      end
    end
  end
endmodule

//--- verif/idcyc_decode_asserts.sv
/*
  Checker for the decode and cycle-count unit: fixed-count groups,
  unknown encodings and the next-instruction component count.
  Assumes binding to idcyc_decode, one clock, synchronous reset.
*/
`timescale 1ns/1ps
module idcyc_decode_chk
(
  input wire       clk_sys,
  input wire       reset_n,
  input wire       clk_en,
  input wire       insn_valid,
  input wire [7:0] insn_byte0,
  input wire [7:0] insn_byte1,
  input wire [1:0] op_mode,
  input wire [3:0] wait_states,
  input wire [1:0] data_accesses,
  input wire       ea_two_regs,
  input wire       opnd_32,
  input wire       opnd_odd,
  input wire       opnd_misaligned,
  input wire [3:0] byte_count,
  input wire       disp_present,
  input wire       imm_present,
  input wire       dec_done,
  input wire       dec_unknown,
  input wire [7:0] dec_clocks,
  input wire [3:0] dec_components,
  input wire [2:0] dec_reg_field,
  input wire       dec_byte_op
);
  // Penalties mask the fixed figures, so only penalty-free requests count
  wire       nowait  = ((wait_states == 4'h0) || (data_accesses == 2'h0)) && !ea_two_regs && !opnd_32 &&
                       !opnd_odd && !opnd_misaligned;
  wire [3:0] comp_in = byte_count + {3'h0, disp_present} + {3'h0, imm_present};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_take(c);
    clk_en && insn_valid && nowait && c;
  endsequence
  AST_COMPONENTS: assert property (clk_en && insn_valid |=> dec_components == $past(comp_in))
    else $error("component count wrong");
  AST_UNKNOWN: assert property (dec_done && dec_unknown |-> dec_clocks == 8'h00)
    else $error("unknown encoding given clocks");
  AST_MOVE_IMM: assert property (s_take(insn_byte0[7:4] == 4'hB) |=> dec_clocks == 8'h02
    && dec_reg_field == $past(insn_byte0[2:0]) && dec_byte_op == !$past(insn_byte0[3]))
    else $error("short immediate move wrong");
  AST_SEG: assert property (s_take(insn_byte0 == 8'h8E && insn_byte1[7:6] == 2'h3)
    |=> dec_clocks == ($past(op_mode[1]) ? 8'h16 : 8'h02))
    else $error("segment load count wrong");
  AST_PUSH: assert property (s_take(insn_byte0[7:3] == 5'h0A) |=> dec_clocks == ($past(op_mode[1]) ? 8'h04 : 8'h02))
    else $error("push count wrong");
  AST_POP: assert property (s_take(insn_byte0[7:3] == 5'h0B) |=> dec_clocks == 8'h06)
    else $error("pop count wrong");
  AST_STORE_ALL: assert property (s_take(insn_byte0 == 8'h60) |=> dec_clocks == ($past(op_mode[1]) ? 8'h22 : 8'h12))
    else $error("push all count wrong");
  AST_INT_FLAG: assert property (s_take(insn_byte0[7:1] == 7'h7D) |=> dec_clocks == 8'h08)
    else $error("interrupt flag count wrong");
  AST_ADJUST: assert property (s_take(insn_byte0[7:1] == 7'h6A && insn_byte1 == 8'h0A)
    |=> dec_clocks == ($past(insn_byte0[0]) ? 8'h13 : 8'h11))
    else $error("adjust count wrong");
endmodule
bind idcyc_decode idcyc_decode_chk idcyc_decode_chk_inst (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
  .insn_valid(insn_valid), .insn_byte0(insn_byte0), .insn_byte1(insn_byte1), .op_mode(op_mode),
  .ea_two_regs(ea_two_regs), .opnd_32(opnd_32), .opnd_odd(opnd_odd), .opnd_misaligned(opnd_misaligned),
  .wait_states(wait_states), .data_accesses(data_accesses), .byte_count(byte_count), .disp_present(disp_present),
  .imm_present(imm_present), .dec_done(dec_done), .dec_unknown(dec_unknown), .dec_clocks(dec_clocks),
  .dec_components(dec_components), .dec_reg_field(dec_reg_field), .dec_byte_op(dec_byte_op));

//--- verif/idcyc_prefetch.sv
/*
  Prefetch-side model: presents one instruction's bytes while req is high.
  Assumes the bench changes req and bytes off the rising edge.
*/
`timescale 1ns/1ps
module idcyc_prefetch
(
  input  wire       clk_sys,
  input  wire       req,
  input  wire [7:0] rb0,
  input  wire [7:0] rb1,
  input  wire [7:0] rb2,
  output wire       insn_valid,
  output wire [7:0] insn_byte0,
  output wire [7:0] insn_byte1,
  output wire [7:0] insn_byte2
);
  reg [7:0] l0_q = 8'h00;
  reg [7:0] l1_q = 8'h00;
  reg [7:0] l2_q = 8'h00;
  // Stale bytes inverted so reading outside valid shows up
  assign insn_valid = req;
  assign insn_byte0 = req ? rb0 : ~l0_q;
  assign insn_byte1 = req ? rb1 : ~l1_q;
  assign insn_byte2 = req ? rb2 : ~l2_q;
  always @(posedge clk_sys)
  begin
    if (req)
    begin
      l0_q <= rb0;
      l1_q <= rb1;
      l2_q <= rb2;
    end
  end
endmodule

//--- verif/test_insn_decode_cycle_timing.sv
/*
  Self-checking bench for the decode and cycle-count unit.
  Assumes a 20 MHz clock and inputs changed on the falling edge.
*/
`timescale 1ns/1ps
module test_insn_decode_cycle_timing;
  reg        clk_sys = 1'b0;
  reg        reset_n = 1'b0;
  reg        clk_en = 1'b1;
  reg        req = 1'b0;
  reg  [7:0] rb0 = 8'h00;
  reg  [7:0] rb1 = 8'h00;
  reg  [7:0] rb2 = 8'h00;
  reg  [1:0] op_mode = 2'h0;
  reg        priv_ok = 1'b0;
  reg        ea_two = 1'b0;
  reg        o32 = 1'b0;
  reg        odd = 1'b0;
  reg        mis = 1'b0;
  reg  [3:0] ws = 4'h0;
  reg  [1:0] da = 2'h0;
  reg  [5:0] msb = 6'h00;
  reg        disp = 1'b0;
  reg        imm = 1'b0;
  reg  [3:0] bc = 4'h2;
  wire       iv, done, bop, rdst, memo, unk;
  wire [7:0] b0, b1, b2, clks;
  wire [3:0] grp, comps;
  wire [2:0] sub, rf;
  integer    fail_count = 0;
  integer    n_compared = 0;
  integer    cyc = 0;
  integer    i;
  always #25 clk_sys = ~clk_sys;
  idcyc_prefetch idcyc_prefetch_inst (.clk_sys(clk_sys), .req(req), .rb0(rb0), .rb1(rb1), .rb2(rb2),
    .insn_valid(iv), .insn_byte0(b0), .insn_byte1(b1), .insn_byte2(b2));
  idcyc_decode idcyc_decode_inst (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .insn_valid(iv),
    .insn_byte0(b0), .insn_byte1(b1), .insn_byte2(b2), .op_mode(op_mode), .priv_ok(priv_ok),
    .ea_two_regs(ea_two), .opnd_32(o32), .opnd_odd(odd), .opnd_misaligned(mis), .wait_states(ws),
    .data_accesses(da), .mult_sig_bits(msb), .disp_present(disp), .imm_present(imm), .byte_count(bc),
    .dec_done(done), .dec_group(grp), .dec_subop(sub), .dec_byte_op(bop), .dec_reg_is_dest(rdst),
    .dec_mem_opnd(memo), .dec_reg_field(rf), .dec_unknown(unk), .dec_clocks(clks), .dec_components(comps));
  task complete_run;
    begin
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task check(input [79:0] what, input [7:0] seen, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
        fail_count = fail_count + 1;
        $display("[ERR] %0s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  // Leaves req high so requests run back to back
  task run(input [7:0] x0, input [7:0] x1, input [7:0] x2, input [7:0] exp);
    begin
      req = 1'b1;
      rb0 = x0;
      rb1 = x1;
      rb2 = x2;
      @(negedge clk_sys);
      check("done", {7'h0, done}, 8'h01);
      check("clocks", clks, exp);
      check("unknown", {7'h0, unk}, {7'h0, exp == 8'h00});
      check("comps", {4'h0, comps}, {4'h0, bc} + disp + imm);
    end
  endtask
  task idle(input [79:0] name);
    begin
      req = 1'b0;
      @(negedge clk_sys);
      check("done", {7'h0, done}, 8'h00);
      $display("test %0s done", name);
    end
  endtask
  task t_move;
    begin
      run(8'hB0, 8'h12, 8'h00, 8'h02);
      check("width", {rf, bop}, 8'h01);
      check("group", {4'h0, grp}, 8'h01);
      run(8'hB9, 8'h00, 8'h00, 8'h02);
      check("width", {rf, bop}, 8'h02);
      run(8'hA0, 8'h00, 8'h00, 8'h04);
      run(8'hA2, 8'h00, 8'h00, 8'h02);
      run(8'h8E, 8'hC0, 8'h00, 8'h02);
      check("memop", {7'h0, memo}, 8'h00);
      run(8'h8E, 8'h00, 8'h00, 8'h05);
      check("memop", {7'h0, memo}, 8'h01);
      op_mode = 2'h2;
      run(8'h8E, 8'hC0, 8'h00, 8'h16);
      run(8'h8E, 8'h00, 8'h00, 8'h17);
      run(8'h0F, 8'hBE, 8'hC0, 8'h03);
      check("subop", {5'h0, sub}, 8'h01);
      run(8'h0F, 8'hB6, 8'h00, 8'h06);
      check("subop", {5'h0, sub}, 8'h00);
      op_mode = 2'h0;
      idle("move");
    end
  endtask
  task t_stack;
    begin
      run(8'h50, 8'h00, 8'h00, 8'h02);
      run(8'h5F, 8'h00, 8'h00, 8'h06);
      run(8'h60, 8'h00, 8'h00, 8'h12);
      check("group", {4'h0, grp}, 8'h04);
      check("subop", {5'h0, sub}, 8'h02);
      op_mode = 2'h2;
      run(8'h53, 8'h00, 8'h00, 8'h04);
      run(8'h58, 8'h00, 8'h00, 8'h06);
      op_mode = 2'h3;
      run(8'h60, 8'h00, 8'h00, 8'h22);
      op_mode = 2'h0;
      idle("stack");
    end
  endtask
  task t_port;
    begin
      imm = 1'b1;
      run(8'hE4, 8'h40, 8'h00, 8'h0E);
      op_mode = 2'h1;
      run(8'hE5, 8'h40, 8'h00, 8'h1B);
      op_mode = 2'h2;
      priv_ok = 1'b1;
      run(8'hE4, 8'h40, 8'h00, 8'h08);
      priv_ok = 1'b0;
      run(8'hE4, 8'h40, 8'h00, 8'h1D);
      imm = 1'b0;
      run(8'hFA, 8'h00, 8'h00, 8'h08);
      run(8'hFB, 8'h00, 8'h00, 8'h08);
      run(8'hF4, 8'h00, 8'h00, 8'h00);
      check("group", {4'h0, grp}, 8'h00);
      idle("port");
      clk_en = 1'b0;
      req = 1'b1;
      rb0 = 8'hB0;
      repeat (2) @(negedge clk_sys);
      check("frozen", {7'h0, done}, 8'h00);
      clk_en = 1'b1;
      run(8'hFA, 8'h00, 8'h00, 8'h08);
      op_mode = 2'h0;
      idle("enable");
    end
  endtask
  task t_arith;
    reg [14:0] ops;
    begin
      ops = {3'h7, 3'h5, 3'h3, 3'h2, 3'h0};
      for (i = 0; i < 5; i = i + 1)
      begin
        run(8'h80, {2'h3, ops[i*3 +: 3], 3'h1}, 8'h00, 8'h02);
        check("subop", {5'h0, sub}, {5'h0, ops[i*3 +: 3]});
        run(8'h81, {2'h0, ops[i*3 +: 3], 3'h3}, 8'h00, (i == 4) ? 8'h05 : 8'h07);
      end
      run(8'h29, 8'hC8, 8'h00, 8'h02);
      run(8'h01, 8'h08, 8'h00, 8'h07);
      check("dir", {7'h0, rdst}, 8'h00);
      run(8'h2B, 8'h08, 8'h00, 8'h06);
      check("dir", {7'h0, rdst}, 8'h01);
      idle("arith");
    end
  endtask
  task t_muldiv;
    begin
      msb = 6'h03;
      run(8'hF6, 8'hE0, 8'h00, 8'h0F);
      check("group", {4'h0, grp}, 8'h08);
      msb = 6'h09;
      run(8'hF6, 8'hE0, 8'h00, 8'h11);
      msb = 6'h14;
      run(8'hF7, 8'hE0, 8'h00, 8'h19);
      msb = 6'h28;
      o32 = 1'b1;
      // Even-address dword memory operands also pay two clocks
      run(8'hF7, 8'h20, 8'h00, 8'h30);
      run(8'hF7, 8'h30, 8'h00, 8'h2D);
      run(8'hF7, 8'hF8, 8'h00, 8'h2B);
      o32 = 1'b0;
      run(8'hF6, 8'hF0, 8'h00, 8'h0E);
      run(8'hF7, 8'h30, 8'h00, 8'h19);
      run(8'hF6, 8'h38, 8'h00, 8'h16);
      run(8'hF7, 8'hF8, 8'h00, 8'h1B);
      run(8'hD4, 8'h0A, 8'h00, 8'h11);
      check("group", {4'h0, grp}, 8'h0A);
      run(8'hD5, 8'h0A, 8'h00, 8'h13);
      run(8'hD0, 8'hC0, 8'h00, 8'h03);
      run(8'hD3, 8'h38, 8'h00, 8'h07);
      run(8'hC0, 8'hE8, 8'h00, 8'h03);
      run(8'hD0, 8'hD0, 8'h00, 8'h09);
      run(8'hD1, 8'h18, 8'h00, 8'h0A);
      idle("muldiv");
    end
  endtask
  task t_penalty;
    begin
      disp = 1'b1;
      mis = 1'b1;
      run(8'h02, 8'h00, 8'h00, 8'h06);
      run(8'h03, 8'h00, 8'h00, 8'h08);
      ea_two = 1'b1;
      run(8'h01, 8'h00, 8'h00, 8'h0C);
      ea_two = 1'b0;
      mis = 1'b0;
      o32 = 1'b1;
      run(8'h03, 8'h00, 8'h00, 8'h08);
      odd = 1'b1;
      run(8'h03, 8'h00, 8'h00, 8'h0A);
      run(8'h01, 8'h00, 8'h00, 8'h0F);
      odd = 1'b0;
      o32 = 1'b0;
      ws = 4'h3;
      da = 2'h2;
      run(8'h03, 8'h00, 8'h00, 8'h0C);
      run(8'hB0, 8'h00, 8'h00, 8'h08);
      ws = 4'h0;
      da = 2'h0;
      disp = 1'b0;
      idle("penalty");
    end
  endtask
  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      fail_count = fail_count + 1;
      complete_run;
    end
  end
  initial
  begin
    repeat (16) @(negedge clk_sys);
    reset_n = 1'b1;
    t_move;
    t_stack;
    t_port;
    t_arith;
    t_muldiv;
    t_penalty;
    complete_run;
  end
endmodule
